/* File: src/pin_sync.sv */
// three-stage synchroniser with polarity and optional debounce
`timescale 1ns/1ps
`include "pwr_cfg.svh"

module pin_sync #(
  parameter logic [`DEB_CNT_W-1:0] DEB_CYCLES = `DEB_CNT_W'(`DEB_CYCLES)
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic pin_n,
  input  wire logic invert,
  input  wire logic deb_en,
  output logic      level
);

  pwr_pkg::pin_state_t state_reg;
  pwr_pkg::pin_state_t state_next;
  logic                cand;

  // a change counts once stages two and three agree; s1 feeds only s2
  always_comb begin
    cand       = 1'b0;
    state_next = state_reg;
    state_next.s1 = pin_n;
    state_next.s2 = state_reg.s1;
    state_next.s3 = state_reg.s2;
    if (state_reg.s2 == state_reg.s3) begin
      cand = ~state_reg.s3 ^ invert;  // invert flips the asserted level
      if (cand == state_reg.lvl) begin
        state_next.cnt = '0;
      end else if (!deb_en || state_reg.cnt == DEB_CYCLES - 1'b1) begin
        state_next.lvl = cand;
        state_next.cnt = '0;
      end else begin
        state_next.cnt = state_reg.cnt + 1'b1;
      end
    end else begin
      state_next.cnt = '0;  // bounce restarts the hold time
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= '{s1: 1'b1, s2: 1'b1, s3: 1'b1, lvl: 1'b0, cnt: '0};
    end else begin
      state_reg <= state_next;
    end
  end

  assign level = state_reg.lvl;

endmodule : pin_sync

/* File: src/power_on_trigger.sv */
// wake enables, global event status and the main power-on output
`timescale 1ns/1ps
`include "pwr_cfg.svh"

// Summary of operation
// - snoop wake enable set: snoop match event turns main power on.
// - usb wake enable set: usb resume event turns main power on.
// - external wake enable set: rising external pin flag turns power on.
// - any enabled trigger drives the power-on output low.
// - once the output is low, triggers have no further effect.
// - soft reset and power-button override clear the wake enables.
// - wake enables keep their value through soft-off.
// - status bits 15 and 13-12 read zero.
// - ring pin assertion sets bit 14, polarity from its shared pin.
// - any smbus event sets bit 11.
// - smbus event is any status bit enabled by the smbus enables.
// - thermal pin assertion sets bit 10, polarity from its shared pin.
// - thermal flag is the shared pin input latch itself.
// - external pin assertion sets bit 9, polarity from its shared pin.
// - polarity and debounce of the shared pin apply to bit 9.
// - external flag cleared by soft reset, kept through soft-off.
// - pme pin low sets bit 8.
// - writing one clears a status bit, writing zero leaves it.
// - power button held four seconds is an override event.
module power_on_trigger #(
  parameter logic [`PBO_CNT_W-1:0] PBO_CYCLES = `PBO_CNT_W'(`PBO_CYCLES),
  parameter logic [`DEB_CNT_W-1:0] DEB_CYCLES = `DEB_CNT_W'(`DEB_CYCLES)
) (
  input  wire logic             CLOCK,
  input  wire logic             RESETN,
  input  wire pwr_pkg::io_req_t IO_REQ,
  output pwr_pkg::io_rsp_t      IO_RSP,
  input  wire logic             SOFT_RESET,
  input  wire logic             SOFT_OFF_STATE,
  input  wire logic             POWER_OFF_REQ,
  input  wire logic             USB_RESUME_FLAG,
  input  wire logic [`SMB_W-1:0] SMB_STATUS,
  input  wire logic [`SMB_W-1:0] SMB_ENABLE,
  input  wire pwr_pkg::pin_cfg_t PIN_CFG,
  input  wire logic             RING_INDICATOR_N,
  input  wire logic             THERMAL_ALARM_N,
  input  wire logic             EXT_SM_INT_PIN_N,
  input  wire logic             PM_EVENT_PIN_N,
  input  wire logic             POWER_BUTTON_N,
  output logic                  MAIN_POWER_ON_N,
  output logic                  SHARED_PIN_THERMAL,
  output logic                  SHARED_PIN_EXT_INT,
  output logic                  POWER_BUTTON_OVERRIDE
);

  pwr_pkg::pwr_state_t state_reg;
  pwr_pkg::pwr_state_t state_next;

  logic        ring_lvl;
  logic        thermal_alarm_n_lvl;
  logic        ext_lvl;
  logic        pme_lvl;
  logic        btn_lvl;
  logic        smb_evt;
  logic        snoop_match_flag;
  logic        ctrl_wr;
  logic        stat_wr;
  logic [15:0] w1c;
  logic        trigger;
  logic        pbo_evt;

  // true when a word access lands on the register at ofs
  function automatic logic addr_hit(input logic [7:0] addr, input logic [7:0] ofs);
    addr_hit = (addr[7:1] == ofs[7:1]);
  endfunction : addr_hit

  // shared pins take their polarity and debounce from the pin settings
  pin_sync #(.DEB_CYCLES(DEB_CYCLES)) u_ring (
    .clk    (CLOCK),
    .rst_n  (RESETN),
    .pin_n  (RING_INDICATOR_N),
    .invert (PIN_CFG.ring_inv),
    .deb_en (PIN_CFG.ring_deb),
    .level  (ring_lvl)
  );

  pin_sync #(.DEB_CYCLES(DEB_CYCLES)) u_thermal_alarm_n (
    .clk    (CLOCK),
    .rst_n  (RESETN),
    .pin_n  (THERMAL_ALARM_N),
    .invert (PIN_CFG.thermal_alarm_n_inv),
    .deb_en (PIN_CFG.thermal_alarm_n_deb),
    .level  (thermal_alarm_n_lvl)
  );

  pin_sync #(.DEB_CYCLES(DEB_CYCLES)) u_ext (
    .clk    (CLOCK),
    .rst_n  (RESETN),
    .pin_n  (EXT_SM_INT_PIN_N),
    .invert (PIN_CFG.ext_inv),
    .deb_en (PIN_CFG.ext_deb),
    .level  (ext_lvl)
  );

  // pme and power button are fixed active low and undebounced
  pin_sync #(.DEB_CYCLES(DEB_CYCLES)) u_pme (
    .clk    (CLOCK),
    .rst_n  (RESETN),
    .pin_n  (PM_EVENT_PIN_N),
    .invert (1'b0),
    .deb_en (1'b0),
    .level  (pme_lvl)
  );

  pin_sync #(.DEB_CYCLES(DEB_CYCLES)) u_btn (
    .clk    (CLOCK),
    .rst_n  (RESETN),
    .pin_n  (POWER_BUTTON_N),
    .invert (1'b0),
    .deb_en (1'b0),
    .level  (btn_lvl)
  );

  // decode of the i/o access and of the event sources
  always_comb begin
    smb_evt          = |(SMB_STATUS & SMB_ENABLE);
    snoop_match_flag = SMB_STATUS[`SMB_SNOOP_BIT];
    ctrl_wr = IO_REQ.sel && IO_REQ.wr && IO_REQ.be[0]
              && addr_hit(IO_REQ.addr, `OFS_WAKE_EN);
    stat_wr = IO_REQ.sel && IO_REQ.wr && IO_REQ.be[1]
              && addr_hit(IO_REQ.addr, `OFS_SMI_STATUS);
    w1c     = stat_wr ? IO_REQ.wdata : 16'h0000;
    // each source counts on its rising edge, so a level that stays
    // high cannot wake the system again right after power-off
    trigger = (state_reg.wake_en[`BIT_SNOOP_EN]
               && snoop_match_flag && !state_reg.snoop_prev)
           || (state_reg.wake_en[`BIT_USB_EN]
               && USB_RESUME_FLAG && !state_reg.usb_prev)
           || (state_reg.wake_en[`BIT_EXT_EN]
               && state_reg.ext && !state_reg.ext_prev);
    pbo_evt = btn_lvl && !state_reg.pbo_hit
              && (state_reg.pbo_cnt == PBO_CYCLES - 1'b1);
  end

  // next state of the whole block
  always_comb begin
    state_next = state_reg;
    state_next.snoop_prev = snoop_match_flag;
    state_next.usb_prev   = USB_RESUME_FLAG;
    state_next.ext_prev   = state_reg.ext;
    state_next.pbo_pulse  = pbo_evt;
    state_next.rsp.valid  = 1'b0;

    // power button hold timer, one override per press
    if (!btn_lvl) begin
      state_next.pbo_cnt = '0;
      state_next.pbo_hit = 1'b0;
    end else if (pbo_evt) begin
      state_next.pbo_hit = 1'b1;
    end else if (!state_reg.pbo_hit) begin
      state_next.pbo_cnt = state_reg.pbo_cnt + 1'b1;
    end

    // wake enables; nothing here looks at soft-off, so they are kept
    if (SOFT_RESET || pbo_evt) begin
      state_next.wake_en = `WAKE_EN_RESET;
    end else if (ctrl_wr) begin
      state_next.wake_en = IO_REQ.wdata[2:0];
    end

    // sticky flags: set beats the write-one clear
    state_next.ring  = (state_reg.ring  & ~w1c[`BIT_RING])
                       | ring_lvl;
    state_next.smb   = (state_reg.smb   & ~w1c[`BIT_SMBUS])
                       | smb_evt;
    state_next.thermal_alarm_n = (state_reg.thermal_alarm_n & ~w1c[`BIT_THERMAL])
                       | thermal_alarm_n_lvl;
    state_next.ext   = (state_reg.ext   & ~w1c[`BIT_EXT_INT])
                       | ext_lvl;
    state_next.pme   = (state_reg.pme   & ~w1c[`BIT_PME])
                       | pme_lvl;
    if (SOFT_RESET) begin
      state_next.ring  = `STATUS_RESET;
      state_next.smb   = `STATUS_RESET;
      state_next.thermal_alarm_n = `STATUS_RESET;
      state_next.ext   = `STATUS_RESET;
      state_next.pme   = `STATUS_RESET;
    end

    // power-on output: only a high output can be pulled low
    if (POWER_OFF_REQ || pbo_evt) begin
      state_next.pwr_on_n = 1'b1;
    end else if (state_reg.pwr_on_n && trigger) begin
      state_next.pwr_on_n = 1'b0;
    end

    // register read, answered one cycle after the request
    if (IO_REQ.sel && IO_REQ.rd) begin
      state_next.rsp.valid = 1'b1;
      state_next.rsp.rdata = 16'h0000;
      if (addr_hit(IO_REQ.addr, `OFS_WAKE_EN)) begin
        state_next.rsp.rdata[2:0] = state_reg.wake_en;
      end else if (addr_hit(IO_REQ.addr, `OFS_SMI_STATUS)) begin
        state_next.rsp.rdata[`BIT_RING]    = state_reg.ring;
        state_next.rsp.rdata[`BIT_SMBUS]   = state_reg.smb;
        state_next.rsp.rdata[`BIT_THERMAL] = state_reg.thermal_alarm_n;
        state_next.rsp.rdata[`BIT_EXT_INT] = state_reg.ext;
        state_next.rsp.rdata[`BIT_PME]     = state_reg.pme;
      end
    end
  end

  // soft-off is a level the block ignores: retention is the default
  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      state_reg          <= '0;
      state_reg.pwr_on_n <= 1'b1;
    end else begin
      state_reg <= state_next;
    end
  end

  // all outputs straight from the state register
  assign IO_RSP                = state_reg.rsp;
  assign MAIN_POWER_ON_N       = state_reg.pwr_on_n;
  assign SHARED_PIN_THERMAL    = state_reg.thermal_alarm_n;
  assign SHARED_PIN_EXT_INT    = state_reg.ext;
  assign POWER_BUTTON_OVERRIDE = state_reg.pbo_pulse;

endmodule : power_on_trigger

/* File: src/pwr_cfg.svh */
// offsets, field positions, reset values and timing counts for the wake logic
`ifndef PWR_CFG_SVH
`define PWR_CFG_SVH

// register byte offsets on the i/o port
`define OFS_WAKE_EN      8'h26
`define OFS_SMI_STATUS   8'h28

// wake enable fields
`define BIT_SNOOP_EN     2
`define BIT_USB_EN       1
`define BIT_EXT_EN       0
`define WAKE_EN_RESET    3'h0

// status fields (bits 15, 13-12 and 7-0 read as zero here)
`define BIT_RING         14
`define BIT_SMBUS        11
`define BIT_THERMAL      10
`define BIT_EXT_INT      9
`define BIT_PME          8
`define STATUS_RESET     1'h0

// position of the snoop match flag inside the smbus status byte
`define SMB_SNOOP_BIT    3
`define SMB_W            8

// clock and timing
`define CLK_FREQ_KHZ     25000
`define PBO_TIME_MS      4000
`define PBO_CYCLES       (`PBO_TIME_MS * `CLK_FREQ_KHZ)
`define PBO_CNT_W        27
`define DEB_TIME_US      16
`define DEB_CYCLES       (`DEB_TIME_US * `CLK_FREQ_KHZ / 1000)
`define DEB_CNT_W        12

`endif

/* File: src/pwr_pkg.sv */
// types shared by the wake logic and its pin conditioner
`include "pwr_cfg.svh"

package pwr_pkg;

  // one i/o access as presented by the host bridge
  typedef struct packed {
    logic        sel;
    logic        wr;
    logic        rd;
    logic [1:0]  be;
    logic [7:0]  addr;
    logic [15:0] wdata;
  } io_req_t;

  // read answer
  typedef struct packed {
    logic        valid;
    logic [15:0] rdata;
  } io_rsp_t;

  // input polarity and debounce settings of the shared pins
  typedef struct packed {
    logic ring_inv;
    logic thermal_alarm_n_inv;
    logic ext_inv;
    logic ring_deb;
    logic thermal_alarm_n_deb;
    logic ext_deb;
  } pin_cfg_t;

  // state of one conditioned pin
  typedef struct packed {
    logic                  s1;
    logic                  s2;
    logic                  s3;
    logic                  lvl;
    logic [`DEB_CNT_W-1:0] cnt;
  } pin_state_t;

  // state of the wake logic
  typedef struct packed {
    logic [2:0]            wake_en;
    logic                  ring;
    logic                  smb;
    logic                  thermal_alarm_n;
    logic                  ext;
    logic                  pme;
    logic                  ext_prev;
    logic                  snoop_prev;
    logic                  usb_prev;
    logic                  pwr_on_n;
    logic [`PBO_CNT_W-1:0] pbo_cnt;
    logic                  pbo_hit;
    logic                  pbo_pulse;
    io_rsp_t               rsp;
  } pwr_state_t;

endpackage : pwr_pkg

/* File: tb/power_on_trigger_asserts.sv */
// port checks for the wake logic, bound to its top module
`timescale 1ns/1ps
`include "pwr_cfg.svh"
module power_on_trigger_asserts #(
  parameter logic [`PBO_CNT_W-1:0] PBO_CYCLES = `PBO_CNT_W'(`PBO_CYCLES)
) (
  input wire logic              CLOCK,
  input wire logic              RESETN,
  input wire pwr_pkg::io_req_t  IO_REQ,
  input wire pwr_pkg::io_rsp_t  IO_RSP,
  input wire logic              SOFT_RESET,
  input wire logic              POWER_OFF_REQ,
  input wire pwr_pkg::pin_cfg_t PIN_CFG,
  input wire logic              THERMAL_ALARM_N,
  input wire logic              EXT_SM_INT_PIN_N,
  input wire logic              POWER_BUTTON_N,
  input wire logic              MAIN_POWER_ON_N,
  input wire logic              SHARED_PIN_THERMAL,
  input wire logic              SHARED_PIN_EXT_INT,
  input wire logic              POWER_BUTTON_OVERRIDE
);
  logic [31:0] low_cnt;
  logic        ext_clr;
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RESETN);
  // button low time; 32 bits cannot wrap within any run
  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      low_cnt <= 32'h0;
    end else begin
      low_cnt <= POWER_BUTTON_N ? 32'h0 : low_cnt + 32'h1;
    end
  end
  // write-one to the status word naming the external flag
  assign ext_clr = IO_REQ.sel && IO_REQ.wr && IO_REQ.be[1] && IO_REQ.wdata[9]
                   && (IO_REQ.addr[7:1] == 7'h14);
  read_answer_a: assert property (IO_REQ.sel && IO_REQ.rd |=> IO_RSP.valid)
    else $error("read not answered");
  valid_cause_a: assert property (IO_RSP.valid |-> $past(IO_REQ.sel && IO_REQ.rd))
    else $error("answer without read");
  status_zero_a: assert property (IO_RSP.valid && $past(IO_REQ.addr[7:1]) == 7'h14
    |-> (IO_RSP.rdata & 16'hb0ff) == 16'h0) else $error("reserved status bits set");
  ext_set_a: assert property ($fell(EXT_SM_INT_PIN_N) && !PIN_CFG.ext_inv
    && !PIN_CFG.ext_deb |-> ##[2:5] SHARED_PIN_EXT_INT) else $error("ext flag late");
  thermal_alarm_n_set_a: assert property ($fell(THERMAL_ALARM_N) && !PIN_CFG.thermal_alarm_n_inv
    && !PIN_CFG.thermal_alarm_n_deb |-> ##[2:5] SHARED_PIN_THERMAL) else $error("thermal flag late");
  // soft reset is the only other legal way to drop the flag
  ext_hold_a: assert property (SHARED_PIN_EXT_INT && !ext_clr && !SOFT_RESET
    |=> SHARED_PIN_EXT_INT) else $error("ext flag lost");
  power_hold_a: assert property ($rose(MAIN_POWER_ON_N) |-> $past(POWER_OFF_REQ)
    || $past(POWER_BUTTON_OVERRIDE) || POWER_BUTTON_OVERRIDE) else $error("power dropped");
  override_time_a: assert property (POWER_BUTTON_OVERRIDE |-> low_cnt >= PBO_CYCLES)
    else $error("override too early");
  override_once_a: assert property (POWER_BUTTON_OVERRIDE |=> !POWER_BUTTON_OVERRIDE)
    else $error("override pulse too long");
endmodule : power_on_trigger_asserts

bind power_on_trigger power_on_trigger_asserts #(.PBO_CYCLES(PBO_CYCLES)) i_chk (
  .CLOCK(CLOCK), .RESETN(RESETN), .IO_REQ(IO_REQ), .IO_RSP(IO_RSP), .SOFT_RESET(SOFT_RESET),
  .POWER_OFF_REQ(POWER_OFF_REQ), .PIN_CFG(PIN_CFG), .THERMAL_ALARM_N(THERMAL_ALARM_N),
  .EXT_SM_INT_PIN_N(EXT_SM_INT_PIN_N), .POWER_BUTTON_N(POWER_BUTTON_N),
  .MAIN_POWER_ON_N(MAIN_POWER_ON_N), .SHARED_PIN_THERMAL(SHARED_PIN_THERMAL),
  .SHARED_PIN_EXT_INT(SHARED_PIN_EXT_INT), .POWER_BUTTON_OVERRIDE(POWER_BUTTON_OVERRIDE));

/* File: tb/power_on_trigger_tb.sv */
// self-checking bench for the wake logic
`timescale 1ns/1ps
module power_on_trigger_tb;
  localparam int     PBO = 20;
  logic              CLOCK = 1'b0;
  logic              RESETN = 1'b0;
  logic              soft_rst = 1'b0;
  logic              soft_off = 1'b0;
  logic              off_req = 1'b0;
  logic              usb = 1'b0;
  logic [7:0]        smb_st = 8'h0;
  logic [7:0]        smb_en = 8'h0;
  logic [4:0]        act = 5'h0;
  logic [15:0]       rd = 16'h0;
  logic [31:0]       seed = 32'hbf746aea;
  pwr_pkg::io_req_t  req = '0;
  pwr_pkg::pin_cfg_t cfg = '0;
  pwr_pkg::io_rsp_t  rsp;
  logic              ring_n, thermal_alarm_n_n, ext_n, pme_n, btn_n, pon_n, th_o, ex_o, pbo;
  int                error_cnt = 0;
  int                num_checks = 0;
  int                exp_en = 0;
  always #20 CLOCK = ~CLOCK;
  power_on_trigger #(.PBO_CYCLES(27'(PBO)), .DEB_CYCLES(12'h4)) i_dut (
    .CLOCK(CLOCK), .RESETN(RESETN), .IO_REQ(req), .IO_RSP(rsp), .SOFT_RESET(soft_rst),
    .SOFT_OFF_STATE(soft_off), .POWER_OFF_REQ(off_req), .USB_RESUME_FLAG(usb),
    .SMB_STATUS(smb_st), .SMB_ENABLE(smb_en), .PIN_CFG(cfg), .RING_INDICATOR_N(ring_n),
    .THERMAL_ALARM_N(thermal_alarm_n_n), .EXT_SM_INT_PIN_N(ext_n), .PM_EVENT_PIN_N(pme_n),
    .POWER_BUTTON_N(btn_n), .MAIN_POWER_ON_N(pon_n), .SHARED_PIN_THERMAL(th_o),
    .SHARED_PIN_EXT_INT(ex_o), .POWER_BUTTON_OVERRIDE(pbo));
  wake_pins i_pins (.CLOCK(CLOCK), .act(act), .RING_INDICATOR_N(ring_n),
    .THERMAL_ALARM_N(thermal_alarm_n_n), .EXT_SM_INT_PIN_N(ext_n), .PM_EVENT_PIN_N(pme_n),
    .POWER_BUTTON_N(btn_n));
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : lfsr
  // all stimulus moves 1 ns after the rising edge
  task automatic cyc(input int n);
    repeat (n) @(posedge CLOCK);
    #1;
  endtask : cyc
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // one access; request stands one cycle, answer taken the cycle after
  task automatic io(input logic w, input logic [7:0] a, input logic [15:0] d);
    req = '{sel: 1'b1, wr: w, rd: !w, be: 2'h3, addr: a, wdata: d};
    cyc(1);
    rd = rsp.rdata;
    chk(16'(rsp.valid), 16'(!w));
    req = '0;
    cyc(1);
  endtask : io
  task automatic rdc(input logic [7:0] a, input logic [15:0] e);
    io(1'b0, a, 16'h0);
    chk(rd, e);
  endtask : rdc
  task automatic srst;
    soft_rst = 1'b1;
    cyc(1);
    soft_rst = 1'b0;
  endtask : srst
  // t: 0 external pin, 1 usb resume, 2 snoop match
  task automatic fire(input int t, input logic on);
    if (t == 0) act[2] = on;
    else if (t == 1) usb = on;
    else smb_st[3] = on;
  endtask : fire
  task automatic summarize;
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : summarize
  // run needs about 470 cycles; 5000 means a hang
  initial begin
    #200000;
    error_cnt++;
    summarize();
  end
  initial begin
    cyc(20);
    RESETN = 1'b1;
    cyc(1);
    chk(16'(pon_n), 16'h1);
    rdc(8'h26, 16'h0);
    rdc(8'h28, 16'h0);
    rdc(8'h40, 16'h0);
    $display("test reset done");
    seed = lfsr(seed);
    exp_en = int'(seed[2:0]);
    io(1'b1, 8'h26, seed[15:0]);
    io(1'b1, 8'h40, 16'hffff);
    soft_off = 1'b1;
    cyc(8);
    rdc(8'h26, 16'(exp_en));
    soft_off = 1'b0;
    srst();
    rdc(8'h26, 16'h0);
    io(1'b1, 8'h26, 16'h0007);
    act[0] = 1'b1;
    // the override must pulse exactly once per press
    rd = 16'h0;
    repeat (PBO + 12) begin
      cyc(1);
      rd = rd + 16'(pbo);
    end
    chk(rd, 16'h1);
    act[0] = 1'b0;
    cyc(4);
    rdc(8'h26, 16'h0);
    $display("test enables done");
    act = 5'h1e;
    cyc(10);
    chk(16'({th_o, ex_o}), 16'h3);
    rdc(8'h28, 16'h4700);
    io(1'b1, 8'h28, 16'hffff);
    rdc(8'h28, 16'h4700);
    act = 5'h0;
    cyc(8);
    io(1'b1, 8'h28, 16'h0);
    rdc(8'h28, 16'h4700);
    srst();
    rdc(8'h28, 16'h0);
    cfg = '{ring_inv: 1'b1, thermal_alarm_n_inv: 1'b1, ext_inv: 1'b1, default: 1'b0};
    cyc(10);
    rdc(8'h28, 16'h4600);
    cfg = '0;
    cyc(8);
    io(1'b1, 8'h28, 16'hffff);
    rdc(8'h28, 16'h0);
    // a glitch shorter than the debounce time must vanish
    cfg = '{ring_deb: 1'b1, thermal_alarm_n_deb: 1'b1, ext_deb: 1'b1, default: 1'b0};
    act = 5'h1c;
    cyc(2);
    act = 5'h0;
    cyc(10);
    rdc(8'h28, 16'h0);
    act = 5'h1c;
    cyc(14);
    rdc(8'h28, 16'h4600);
    act = 5'h0;
    cfg = '0;
    cyc(8);
    io(1'b1, 8'h28, 16'hffff);
    $display("test status done");
    repeat (6) begin
      seed = lfsr(seed);
      smb_st = seed[7:0];
      smb_en = seed[15:8];
      cyc(4);
      rdc(8'h28, |(seed[7:0] & seed[15:8]) ? 16'h0800 : 16'h0);
      smb_st = 8'h0;
      cyc(2);
      io(1'b1, 8'h28, 16'hffff);
    end
    smb_en = 8'h0;
    $display("test smbus done");
    for (int k = 0; k < 3; k++) begin
      io(1'b1, 8'h26, 16'(1 << k));
      for (int t = 0; t < 3; t++) begin
        fire(t, 1'b1);
        cyc(12);
        chk(16'(pon_n), 16'(t != k));
        fire(t, 1'b0);
        cyc(8);
        io(1'b1, 8'h28, 16'hffff);
        off_req = 1'b1;
        cyc(1);
        off_req = 1'b0;
        cyc(2);
        chk(16'(pon_n), 16'h1);
      end
    end
    $display("test wake done");
    summarize();
  end
endmodule : power_on_trigger_tb

/* File: tb/wake_pins.sv */
// far-side model: wake pins and power button with pull-ups
`timescale 1ns/1ps
module wake_pins (
  input  wire logic       CLOCK,
  input  wire logic [4:0] act,
  output logic            RING_INDICATOR_N,
  output logic            THERMAL_ALARM_N,
  output logic            EXT_SM_INT_PIN_N,
  output logic            PM_EVENT_PIN_N,
  output logic            POWER_BUTTON_N
);
  // released pins sit at the pull-up; edges land 3 ns after the clock,
  // so the block's synchronisers see them at a fixed offset from the clock
  initial {RING_INDICATOR_N, THERMAL_ALARM_N, EXT_SM_INT_PIN_N, PM_EVENT_PIN_N,
           POWER_BUTTON_N} = 5'h1f;
  always @(posedge CLOCK) begin
    {RING_INDICATOR_N, THERMAL_ALARM_N, EXT_SM_INT_PIN_N, PM_EVENT_PIN_N,
     POWER_BUTTON_N} <= #3 ~act;
  end
endmodule : wake_pins
